// file: fwc_defs.svh
// Constants of the fault warning controller: offsets, fields, reset values, timing counts
`ifndef FWC_DEFS_SVH
`define FWC_DEFS_SVH
`define FWC_NZONE 8
`define FWC_CLK_MHZ 250
`define FWC_OFF_CTRL 12'h000
`define FWC_OFF_ZFLT 12'h004
`define FWC_OFF_ZMASK 12'h008
`define FWC_OFF_SRC 12'h00c
`define FWC_OFF_STAT 12'h010
`define FWC_OFF_BROWSE 12'h014
`define FWC_OFF_CMD 12'h018
`define FWC_CMD_SILENCE 0
`define FWC_CMD_RESET 1
`define FWC_CMD_BROWSE 2
`define FWC_CTRL_AUTO 0
`define FWC_CTRL_LVL 2:1
`define FWC_CTRL_ALARM 3
`define FWC_CTRL_RESET 32'h0000_0001
`define FWC_ENTRY_S 100
`define FWC_RESTORE_S 20
`define FWC_HOLD_S 3600
`define FWC_FLASH_CYC 32'd62500000
`endif

// file: fwc_pkg.sv
// Types of the fault warning controller
package fwc_pkg;
  typedef struct packed {
    logic [7:0] zone_short;
    logic [7:0] zone_open;
    logic [7:0] zone_removed;
    logic [7:0] point_fault;
    logic [7:0] zone_alarm;
    logic [7:0] zone_disabled;
    logic [7:0] zone_test;
    logic power_fault;
    logic earth_fault;
    logic fuse_fault;
    logic link_fault_mand;
    logic link_fault_minor;
    logic circuit_fault_minor;
    logic protect_path_fault;
    logic routing_path_fault;
    logic sounder_path_fault;
    logic alarm_route_fault;
    logic standby_lost;
    logic system_fault;
    logic fire_alarm;
  } fwc_in_type;
  typedef struct packed {
    logic general_fault;
    logic system_fault;
    logic [7:0] zone_lamp;
    logic power;
    logic earth;
    logic fuse;
    logic link;
    logic protect_path;
    logic routing_path;
    logic sounder_path;
    logic alarm_route;
    logic buzzer;
    logic hidden_entries;
    logic fault_out_n;
  } fwc_out_type;
  typedef enum logic [1:0] {fwc_idle, fwc_data} fwc_bus_state_type;
endpackage

// file: fwc_timer.sv
// Qualification timer: counts cycles while a condition holds
`timescale 1ns/1ps
module fwc_timer
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic run,
  input wire logic [31:0] limit,
  output logic done
);
  logic [31:0] count;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      count <= 32'h0;
    else if (!run)
      count <= 32'h0;
    else if (count < limit)
      count <= count + 32'h1;
  end
  assign done = run && (count >= limit);
endmodule

// file: fwc_top.sv
// Fault warning controller with AHB-Lite register slave
//
// Design decisions made here: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ps
`include "fwc_defs.svh"
module fwc_top
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire fwc_pkg::fwc_in_type fault_in,
  output fwc_pkg::fwc_out_type ind
);
  localparam longint unsigned ENTRY_CYC =
    64'(`FWC_ENTRY_S) * 64'(`FWC_CLK_MHZ) * 64'd1000000;
  localparam longint unsigned HOLD_CYC =
    64'(`FWC_HOLD_S) * 64'(`FWC_CLK_MHZ) * 64'd1000000;
  // Raw fault must persist this long before recognition; well under 100 s
  parameter logic [31:0] QUAL_CYC = 32'd250000;
  // Sounder hold after standby loss: one hour
  parameter logic [39:0] HOLD_LEN = 40'(HOLD_CYC);

  function automatic logic [31:0] fwc_word(input logic [11:0] a);
    fwc_word = {20'h0, a};
  endfunction

  // Bus slave
  logic [11:0] addr_q;
  logic wr_q;
  logic rd_q;
  logic [31:0] ctrl;
  logic [7:0] zmask_view;
  logic [3:0] browse_idx;
  wire take = hsel && hready && htrans[1];
  wire wr_ctrl = wr_q && addr_q == `FWC_OFF_CTRL;
  wire wr_cmd = wr_q && addr_q == `FWC_OFF_CMD;
  wire op_level_ok = ctrl[`FWC_CTRL_LVL] == 2'd1 || ctrl[`FWC_CTRL_LVL] == 2'd2;
  wire mgr_level_ok = ctrl[`FWC_CTRL_LVL] == 2'd2 || ctrl[`FWC_CTRL_LVL] == 2'd3;
  wire cmd_silence = wr_cmd && hwdata[`FWC_CMD_SILENCE] && op_level_ok;
  wire cmd_reset = wr_cmd && hwdata[`FWC_CMD_RESET] && mgr_level_ok;
  wire cmd_browse = wr_cmd && hwdata[`FWC_CMD_BROWSE] && op_level_ok;
  wire auto_reset = ctrl[`FWC_CTRL_AUTO];
  wire fire = fault_in.fire_alarm || ctrl[`FWC_CTRL_ALARM];

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      addr_q <= 12'h0;
      wr_q <= 1'b0;
      rd_q <= 1'b0;
    end
    else
    begin
      addr_q <= haddr[11:0];
      wr_q <= take && hwrite;
      rd_q <= take && !hwrite;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      ctrl <= `FWC_CTRL_RESET;
    else if (wr_ctrl)
      ctrl <= {28'h0, hwdata[3:0]};
  end

  // Zone fault recognition with masks
  wire [7:0] zone_raw = fault_in.zone_short | fault_in.zone_open | fault_in.zone_removed
    | fault_in.point_fault;
  wire [7:0] zone_mask = fault_in.zone_alarm | fault_in.zone_disabled | fault_in.zone_test;
  wire [7:0] zone_cand = zone_raw & ~zone_mask;
  wire [7:0] zone_ok;
  wire [9:0] func_cand = {fault_in.power_fault, fault_in.earth_fault, fault_in.fuse_fault,
    fault_in.link_fault_mand, fault_in.protect_path_fault, fault_in.routing_path_fault,
    fault_in.sounder_path_fault, fault_in.alarm_route_fault, fault_in.link_fault_minor,
    fault_in.circuit_fault_minor};
  wire [9:0] func_ok;

  genvar g;
  generate
    for (g = 0; g < 18; g++)
    begin : qual
      if (g < 8)
      begin : z
        fwc_timer u_t (.hclk(hclk), .hresetn(hresetn), .run(zone_cand[g]),
          .limit(QUAL_CYC), .done(zone_ok[g]));
      end
      else
      begin : f
        fwc_timer u_t (.hclk(hclk), .hresetn(hresetn), .run(func_cand[g-8]),
          .limit(QUAL_CYC), .done(func_ok[g-8]));
      end
    end
  endgenerate

  // Latched recognised faults; live ones set, reset clears only cleared ones
  logic [7:0] zone_lat;
  logic [9:0] func_lat;
  logic sys_lat;
  logic buzz;
  logic [7:0] zone_prev;
  logic [9:0] func_prev;
  logic sys_prev;
  wire [7:0] next_zone_lat = auto_reset ? zone_ok : ((cmd_reset ? 8'h0 : zone_lat) | zone_ok);
  wire [9:0] next_func_lat = auto_reset ? func_ok : ((cmd_reset ? 10'h0 : func_lat) | func_ok);
  wire next_sys_lat = (cmd_reset ? 1'b0 : sys_lat) | fault_in.system_fault;
  wire any_fault = (|zone_lat) || (|func_lat) || sys_lat;
  wire new_fault = (|(zone_ok & ~zone_prev)) || (|(func_ok & ~func_prev))
    || (fault_in.system_fault && !sys_prev);
  wire next_any = (|next_zone_lat) || (|next_func_lat) || next_sys_lat;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      zone_lat <= 8'h0;
      func_lat <= 10'h0;
      sys_lat <= 1'b0;
      zone_prev <= 8'h0;
      func_prev <= 10'h0;
      sys_prev <= 1'b0;
    end
    else
    begin
      zone_lat <= next_zone_lat;
      func_lat <= next_func_lat;
      sys_lat <= next_sys_lat;
      zone_prev <= zone_ok;
      func_prev <= func_ok;
      sys_prev <= fault_in.system_fault;
    end
  end

  // Sounder: new fault wins over silence; cleared with the condition
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      buzz <= 1'b0;
    else if (new_fault)
      buzz <= 1'b1;
    else if (!next_any)
      buzz <= 1'b0;
    else if (cmd_silence)
      buzz <= 1'b0;
  end

  // Standby loss hold timer
  logic [39:0] hold_cnt;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hold_cnt <= 40'h0;
    else if (fault_in.standby_lost)
      hold_cnt <= HOLD_LEN;
    else if (hold_cnt != 40'h0)
      hold_cnt <= hold_cnt - 40'h1;
  end

  // Slow flash distinguishes faults from steady disable and test lamps
  logic [31:0] flash_cnt;
  logic flash;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      flash_cnt <= 32'h0;
      flash <= 1'b0;
    end
    else if (flash_cnt >= `FWC_FLASH_CYC - 32'h1)
    begin
      flash_cnt <= 32'h0;
      flash <= !flash;
    end
    else
      flash_cnt <= flash_cnt + 32'h1;
  end

  // Hidden entries and browse pointer over latched zone faults
  logic [7:0] zone_seen;
  wire [7:0] zone_hidden = zone_lat & ~zone_seen;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      browse_idx <= 4'h0;
      zone_seen <= 8'h0;
    end
    else
    begin
      zone_seen <= zone_seen & zone_lat;
      if (cmd_browse)
      begin
        browse_idx <= browse_idx + 4'h1;
        zone_seen[browse_idx[2:0]] <= zone_lat[browse_idx[2:0]];
      end
    end
  end
  assign zmask_view = zone_mask;

  // Indicator outputs, all registered
  wire [7:0] zone_test_dis = fault_in.zone_disabled | fault_in.zone_test;
  wire [7:0] zone_lamp_v = (zone_lat & {8{flash && !fire}}) | (zone_test_dis & ~zone_lat);
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      ind <= '{fault_out_n: 1'b0, default: 1'b0};
    else
    begin
      ind.general_fault <= any_fault;
      ind.system_fault <= sys_lat;
      ind.zone_lamp <= zone_lamp_v;
      ind.power <= func_lat[9] && !fire;
      ind.earth <= func_lat[8] && !fire;
      ind.fuse <= func_lat[7] && !fire;
      ind.link <= func_lat[6] && !fire;
      ind.protect_path <= func_lat[5] && !fire;
      ind.routing_path <= func_lat[4] && !fire;
      ind.sounder_path <= func_lat[3];
      ind.alarm_route <= func_lat[2];
      ind.buzzer <= buzz || (hold_cnt != 40'h0);
      ind.hidden_entries <= |zone_hidden;
      ind.fault_out_n <= !any_fault;
    end
  end

  // Read mux
  wire [31:0] stat_w = {24'h0, buzz, sys_lat, |zone_hidden, any_fault, 4'h0};
  wire [31:0] rd_mux =
    addr_q == `FWC_OFF_CTRL ? ctrl :
    addr_q == `FWC_OFF_ZFLT ? {24'h0, zone_lat} :
    addr_q == `FWC_OFF_ZMASK ? {24'h0, zmask_view} :
    addr_q == `FWC_OFF_SRC ? {22'h0, func_lat} :
    addr_q == `FWC_OFF_STAT ? stat_w :
    addr_q == `FWC_OFF_BROWSE ? {23'h0, zone_lat[browse_idx[2:0]], 4'h0, browse_idx} :
    32'h0;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h0;
    else if (take && !hwrite)
      hrdata <= 32'h0;
    else
      hrdata <= rd_q ? rd_mux : 32'h0;
  end
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      hreadyout <= !(take && !hwrite);
      hresp <= 1'b0;
    end
  end
  wire unused_ok = ^{hsize, fwc_word(addr_q), ENTRY_CYC[0], fault_in.zone_alarm[0]};
endmodule

// file: fwc_field.sv
// Field side model: detection points, circuits and routing paths
`timescale 1ns/1ps
module fwc_field
(
  input wire logic hclk,
  input wire fwc_pkg::fwc_in_type want,
  output fwc_pkg::fwc_in_type fault_in
);
  // Field lines settle one clock after the monitored condition changes
  always @(posedge hclk)
    fault_in <= want;
endmodule

// file: fwc_properties.sv
// Concurrent checks on the fault warning controller ports
`timescale 1ns/1ps
module fwc_properties
#(
  parameter logic [31:0] QUAL_CYC = 32'd250000
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire fwc_pkg::fwc_in_type fault_in,
  input wire fwc_pkg::fwc_out_type ind
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic [31:0] pcnt;
  wire rd_taken = hsel && hready && htrans[1] && !hwrite;
  wire cmd_wr = hsel && hready && htrans[1] && hwrite && (haddr[7:0] == 8'h18);
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      pcnt <= 32'h0;
    else
      pcnt <= fault_in.power_fault ? pcnt + 32'h1 : 32'h0;
  sequence read_wait;
    !hreadyout ##1 hreadyout;
  endsequence
  sequence sounder_path_held;
    fault_in.sounder_path_fault [*8];
  endsequence
  a_bus_okay:
    assert property (hresp == 1'b0) else $error("response not okay");
  a_read_wait:
    assert property (rd_taken |=> read_wait) else $error("read wait state wrong");
  a_fault_entry:
    assert property (pcnt > QUAL_CYC + 32'h2 |-> ind.general_fault) else $error("no fault entry");
  a_power_lamp:
    assert property (pcnt > QUAL_CYC + 32'h2 && !fault_in.fire_alarm && !$past(fault_in.fire_alarm)
      |-> ind.power) else $error("power lamp missing");
  a_sounder_path:
    assert property (sounder_path_held |-> ind.sounder_path) else $error("path lamp missing");
  a_system_general:
    assert property (ind.system_fault |-> ind.general_fault) else $error("system without general");
  a_system_latch:
    assert property ($fell(ind.system_fault) |-> $past(cmd_wr, 1) || $past(cmd_wr, 2)
      || $past(cmd_wr, 3)) else $error("system lamp dropped");
  a_auto_quiet:
    assert property ($fell(ind.general_fault) |-> !ind.buzzer) else $error("buzzer left on");
  a_entry_sounds:
    assert property ($rose(ind.general_fault) |-> ind.buzzer) else $error("no buzzer on entry");
  a_standby_hold:
    assert property ($fell(fault_in.standby_lost) |-> ind.buzzer [*8])
      else $error("standby hold short");
  a_fault_out:
    assert property (ind.general_fault |-> !ind.fault_out_n) else $error("fault output idle");
endmodule
bind fwc_top fwc_properties #(.QUAL_CYC(QUAL_CYC)) chk_u (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .fault_in(fault_in), .ind(ind));

// file: fault_warning_controller_bench.sv
// Self-checking bench for the fault warning controller
`timescale 1ns/1ps
module fault_warning_controller_bench;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] rd;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  fwc_pkg::fwc_in_type want = '0;
  fwc_pkg::fwc_in_type fault_in;
  fwc_pkg::fwc_out_type ind;
  int fails = 0;
  int samples_checked = 0;
  initial forever #2 hclk = ~hclk;
  fwc_field field_u (.hclk(hclk), .want(want), .fault_in(fault_in));
  fwc_top #(.QUAL_CYC(32'd4), .HOLD_LEN(40'd20)) dut_u (.hclk(hclk), .hresetn(hresetn),
    .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .fault_in(fault_in), .ind(ind));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Waits for general fault (sel 0) or buzzer (sel 1) to reach a level
  task automatic wait_for(input int sel, input logic v);
    for (int n = 0; n < 60; n++)
    begin
      @(posedge hclk);
      if ((sel == 0 ? ind.general_fault : ind.buzzer) === v)
        return;
    end
    fails++;
    wrap_up();
  endtask
  task automatic wait_ready;
    for (int n = 0; n < 60; n++)
    begin
      @(posedge hclk);
      if (hreadyout === 1'b1)
        return;
    end
    fails++;
    wrap_up();
  endtask
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    wait_ready();
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
    rd = hrdata;
  endtask
  task automatic t_idle;
    bus(1'b0, 32'h0, 32'h0);
    check(rd, 32'h1);
    bus(1'b0, 32'h40, 32'h0);
    check(rd, 32'h0);
    check(ind.fault_out_n, 32'h1);
    $display("test idle done");
  endtask
  task automatic t_power;
    bus(1'b1, 32'h0, 32'h3);
    want.power_fault <= 1'b1;
    wait_for(0, 1'b1);
    check(ind.power, 32'h1);
    check(ind.buzzer, 32'h1);
    check(ind.fault_out_n, 32'h0);
    bus(1'b1, 32'h18, 32'h1);
    wait_for(1, 1'b0);
    want.earth_fault <= 1'b1;
    want.fuse_fault <= 1'b1;
    want.link_fault_mand <= 1'b1;
    want.protect_path_fault <= 1'b1;
    want.alarm_route_fault <= 1'b1;
    wait_for(1, 1'b1);
    check(ind.earth, 32'h1);
    check(ind.fuse, 32'h1);
    check(ind.link, 32'h1);
    check(ind.protect_path, 32'h1);
    check(ind.alarm_route, 32'h1);
    bus(1'b0, 32'hc, 32'h0);
    check(rd, 32'h3e4);
    want <= '0;
    wait_for(0, 1'b0);
    check(ind.buzzer, 32'h0);
    $display("test power done");
  endtask
  task automatic t_zone;
    want.zone_short <= 8'h15;
    want.zone_disabled <= 8'h01;
    want.zone_test <= 8'h04;
    want.zone_alarm <= 8'h10;
    repeat (12) @(posedge hclk);
    bus(1'b0, 32'h4, 32'h0);
    check(rd, 32'h0);
    check(ind.general_fault, 32'h0);
    check(ind.zone_lamp, 32'h5);
    bus(1'b0, 32'h8, 32'h0);
    check(rd, 32'h15);
    want <= '0;
    repeat (2) @(posedge hclk);
    for (int k = 0; k < 4; k++)
    begin
      {want.zone_short, want.zone_open, want.zone_removed, want.point_fault}
        <= 32'h1 << (8 * (3 - k) + 2 * k + 1);
      wait_for(0, 1'b1);
      bus(1'b0, 32'h4, 32'h0);
      check(rd, 32'h1 << (2 * k + 1));
      if (k == 0)
      begin
        check(ind.hidden_entries, 32'h1);
        bus(1'b1, 32'h18, 32'h4);
        bus(1'b0, 32'h14, 32'h0);
        check(rd, 32'h101);
        bus(1'b1, 32'h18, 32'h4);
        repeat (2) @(posedge hclk);
        check(ind.hidden_entries, 32'h0);
      end
      {want.zone_short, want.zone_open, want.zone_removed, want.point_fault} <= 32'h0;
      wait_for(0, 1'b0);
    end
    want.link_fault_minor <= 1'b1;
    wait_for(0, 1'b1);
    want.link_fault_minor <= 1'b0;
    wait_for(0, 1'b0);
    want.circuit_fault_minor <= 1'b1;
    wait_for(0, 1'b1);
    want.circuit_fault_minor <= 1'b0;
    wait_for(0, 1'b0);
    $display("test zone done");
  endtask
  task automatic t_fire;
    want.fire_alarm <= 1'b1;
    want.routing_path_fault <= 1'b1;
    want.sounder_path_fault <= 1'b1;
    want.alarm_route_fault <= 1'b1;
    wait_for(0, 1'b1);
    repeat (2) @(posedge hclk);
    check(ind.sounder_path, 32'h1);
    check(ind.alarm_route, 32'h1);
    check(ind.routing_path, 32'h0);
    want <= '0;
    wait_for(0, 1'b0);
    $display("test fire done");
  endtask
  task automatic t_system;
    want.system_fault <= 1'b1;
    wait_for(0, 1'b1);
    check(ind.system_fault, 32'h1);
    check(ind.buzzer, 32'h1);
    want.system_fault <= 1'b0;
    // Level 1 may not reset a latched system fault
    bus(1'b1, 32'h18, 32'h2);
    repeat (12) @(posedge hclk);
    check(ind.system_fault, 32'h1);
    bus(1'b1, 32'h0, 32'h5);
    bus(1'b1, 32'h18, 32'h2);
    wait_for(0, 1'b0);
    check(ind.system_fault, 32'h0);
    $display("test system done");
  endtask
  task automatic t_standby;
    want.standby_lost <= 1'b1;
    wait_for(1, 1'b1);
    want.standby_lost <= 1'b0;
    repeat (18) @(posedge hclk);
    check(ind.buzzer, 32'h1);
    check(ind.general_fault, 32'h0);
    wait_for(1, 1'b0);
    $display("test standby done");
  endtask
  initial
  begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_idle();
    t_power();
    t_zone();
    t_fire();
    t_system();
    t_standby();
    wrap_up();
  end
endmodule
